// File: temp_status_id_smbus_cfg.sv
// Temperature result, identity and bus configuration registers behind a
// two-wire serial slave. Assumes sensor value, limits and locks come from
// logic on the system clock; the serial pins are sampled on the link clock.
//
// What this block does
// - Critical flag sets at threshold, clears below hysteresis
// - Over flag sets above limit, hysteresis when falling
// - Under flag sets below limit, hysteresis when falling
// - Bit 12 carries the reading's sign
// - Bits 11:1 two's complement eighths; bit 0 zero
// - Fixed read-only sixteen-bit maker identifier
// - Part identifier high byte, revision low byte
// - Time-out disable resets zero, host may set
// - Alert response disable resets zero, host may set
// - Config writes ignored while any lock set
// - Reserved config bits read zero, read-only
// - New conversion every period after bus stop
`timescale 1ns/1ps
`default_nettype none

module temp_status_id_smbus_cfg
  import temp_status_pkg::*;
#(
  parameter int CONV_CYCLES    = temp_status_pkg::CONV_CYCLES_DFLT,
  parameter int TIMEOUT_CYCLES = temp_status_pkg::TIMEOUT_CYCLES_DFLT
)
(
  // System clock and reset
  input  wire logic                     clk_sys_in,
  input  wire logic                     reset_in,
  // Sensor side, system clock domain
  input  wire logic [10:0]              sensor_temp_in,
  input  wire temp_status_pkg::limits_s limits_in,
  input  wire logic                     crit_lock_in,
  input  wire logic                     window_lock_in,
  // Serial link
  input  wire logic                     clk_link_in,
  input  wire logic [2:0]               addr_pins_in,
  input  wire logic                     scl_in,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe_out
);
  import temp_status_pkg::*;

  // ****************************************************************
  // State carriers
  // ****************************************************************
  typedef struct packed {
    logic        wr_s1, wr_s2, wr_d;        // Write toggle sync
    logic        rq_s1, rq_s2, rq_d;        // Read request toggle sync
    logic        st_s1, st_s2, st_d;        // Stop toggle sync
    logic        ack_tgl;                   // Read answer toggle
    logic [15:0] rd_word;                   // Word handed to the link
    logic [15:0] result;                    // Temperature result
    logic        tmo_dis;                   // Bus time-out disable
    logic        ara_dis;                   // Alert response disable
    logic [31:0] conv_cnt;                  // Cycles to next conversion
  } sys_state_s;

  typedef struct packed {
    logic        scl_s1, scl_s2, scl_d;     // Clock pin sync and history
    logic        sda_s1, sda_s2, sda_d;     // Data pin sync and history
    logic [2:0]  ap_s1, ap_s2;              // Address strap sync
    logic        ack_s1, ack_s2, ack_d;     // Read answer sync
    logic        tmo_s1, tmo_s2;            // Time-out disable sync
    logic        ara_s1, ara_s2;            // Alert response disable sync
    link_state_e state;                     // Protocol state
    logic [3:0]  cnt;                       // Bit counter
    logic [7:0]  shift;                     // Byte shifter
    logic [7:0]  ptr;                       // Register pointer
    logic        ara;                       // Alert response cycle
    logic        hi_done;                   // High byte already moved
    logic [15:0] wdata;                     // Assembled write word
    logic [15:0] rdata;                     // Word from system side
    logic        wr_tgl, rq_tgl, st_tgl;    // Event toggles to system side
    logic        drive;                     // Pull data line low
    logic [31:0] to_cnt;                    // Clock-low time-out counter
  } link_state_s;

  sys_state_s  s_reg, s_next;
  link_state_s l_reg, l_next;
  logic        lrst_s1, lrst_s2;            // Reset resynchronised to link

  // Register read mux, used only by the read answer path
  function automatic logic [15:0] reg_select(input logic [7:0] p, input logic [15:0] res,
                                             input logic tmo, input logic ara);
    case (p)
      PTR_TEMP:  reg_select = res;
      PTR_MAKER: reg_select = MAKER_ID;
      PTR_PART:  reg_select = {PART_ID, PART_REV};
      PTR_CFG:   reg_select = {8'h00, tmo, 6'h00, ara};
      default:   reg_select = 16'h0000;
    endcase
  endfunction

  // ****************************************************************
  // System domain
  // ****************************************************************
  logic               wr_evt, rq_evt, st_evt, upd, locked;
  logic signed [11:0] t_ext;
  assign wr_evt = s_reg.wr_s2 ^ s_reg.wr_d;
  assign rq_evt = s_reg.rq_s2 ^ s_reg.rq_d;
  assign st_evt = s_reg.st_s2 ^ s_reg.st_d;
  assign upd    = !st_evt && (s_reg.conv_cnt == 32'h0);
  assign locked = crit_lock_in | window_lock_in;
  assign t_ext  = {sensor_temp_in[10], sensor_temp_in};

  // Next system state
  always_comb
  begin
    logic c_f, o_f, u_f;
    c_f = 1'b0;
    o_f = 1'b0;
    u_f = 1'b0;
    s_next = s_reg;
    // Toggles from the link: second stage only feeds the edge compare
    s_next.wr_s1 = l_reg.wr_tgl;
    s_next.wr_s2 = s_reg.wr_s1;
    s_next.wr_d  = s_reg.wr_s2;
    s_next.rq_s1 = l_reg.rq_tgl;
    s_next.rq_s2 = s_reg.rq_s1;
    s_next.rq_d  = s_reg.rq_s2;
    s_next.st_s1 = l_reg.st_tgl;
    s_next.st_s2 = s_reg.st_s1;
    s_next.st_d  = s_reg.st_s2;
    // Pointer and data hold still until the toggle lands, so reading them here is safe
    if (wr_evt && l_reg.ptr == PTR_CFG && !locked)
    begin
      s_next.tmo_dis = l_reg.wdata[BIT_TMO_DIS];
      s_next.ara_dis = l_reg.wdata[BIT_ARA_DIS];
    end
    // Answer a read request with a snapshot of one register
    if (rq_evt)
    begin
      s_next.rd_word = reg_select(l_reg.ptr, s_reg.result, s_reg.tmo_dis, s_reg.ara_dis);
      s_next.ack_tgl = ~s_reg.ack_tgl;
    end
    // Conversion timer restarts on every bus stop
    if (st_evt)
      s_next.conv_cnt = 32'(CONV_CYCLES - 1);
    else if (upd)
    begin
      // Hysteresis: a set upper flag compares against the limit minus hysteresis
      c_f = s_reg.result[BIT_CRIT] ? (t_ext >= limits_in.crit - limits_in.hyst)
                                   : (t_ext >= limits_in.crit);
      o_f = s_reg.result[BIT_OVER] ? (t_ext > limits_in.upper - limits_in.hyst)
                                   : (t_ext > limits_in.upper);
      // Under flag sets only below limit minus hysteresis and clears at the limit,
      // so a reading between the two cannot make it toggle every conversion
      u_f = s_reg.result[BIT_UNDER] ? (t_ext < limits_in.lower)
                                    : (t_ext < limits_in.lower - limits_in.hyst);
      // One assignment so value and flags never mix conversions
      s_next.result = {c_f, o_f, u_f, sensor_temp_in[10], sensor_temp_in, 1'b0};
      s_next.conv_cnt = 32'(CONV_CYCLES - 1);
    end
    else
      s_next.conv_cnt = s_reg.conv_cnt - 32'h1;
  end

  // System state register
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      s_reg         <= '0;
      s_reg.result  <= TEMP_RESET;
      s_reg.tmo_dis <= CFG_RESET;
      s_reg.ara_dis <= CFG_RESET;
      s_reg.conv_cnt <= 32'(CONV_CYCLES - 1);
    end
    else
      s_reg <= s_next;
  end

  // ****************************************************************
  // Link domain
  // ****************************************************************
  logic start_c, stop_c, rise_c, fall_c, tmo_hit;
  assign start_c = l_reg.scl_s2 && l_reg.sda_d && !l_reg.sda_s2;
  assign stop_c  = l_reg.scl_s2 && !l_reg.sda_d && l_reg.sda_s2;
  assign rise_c  = l_reg.scl_s2 && !l_reg.scl_d;
  assign fall_c  = !l_reg.scl_s2 && l_reg.scl_d;
  assign tmo_hit = (l_reg.to_cnt >= 32'(TIMEOUT_CYCLES - 1));

  // Reset crossing: hold reset long enough for this to see it
  always_ff @(posedge clk_link_in)
  begin
    lrst_s1 <= reset_in;
    lrst_s2 <= lrst_s1;
  end

  // Next link state
  always_comb
  begin
    l_next = l_reg;
    l_next.scl_s1 = scl_in;
    l_next.scl_s2 = l_reg.scl_s1;
    l_next.scl_d  = l_reg.scl_s2;
    l_next.sda_s1 = sda_in;
    l_next.sda_s2 = l_reg.sda_s1;
    l_next.sda_d  = l_reg.sda_s2;
    l_next.ap_s1  = addr_pins_in;
    l_next.ap_s2  = l_reg.ap_s1;
    l_next.ack_s1 = s_reg.ack_tgl;
    l_next.ack_s2 = l_reg.ack_s1;
    l_next.ack_d  = l_reg.ack_s2;
    l_next.tmo_s1 = s_reg.tmo_dis;
    l_next.tmo_s2 = l_reg.tmo_s1;
    l_next.ara_s1 = s_reg.ara_dis;
    l_next.ara_s2 = l_reg.ara_s1;
    // Capture the answered word once its toggle has crossed
    if (l_reg.ack_s2 != l_reg.ack_d)
      l_next.rdata = s_reg.rd_word;
    // Time-out counts clock-low time inside a transfer unless disabled
    if (l_reg.state == L_IDLE || l_reg.scl_s2 || l_reg.tmo_s2)
      l_next.to_cnt = 32'h0;
    else if (!tmo_hit)
      l_next.to_cnt = l_reg.to_cnt + 32'h1;
    if (start_c)
    begin
      l_next.state = L_ADDR;
      l_next.cnt   = 4'h0;
      l_next.drive = 1'b0;
    end
    else if (stop_c)
    begin
      l_next.state  = L_IDLE;
      l_next.drive  = 1'b0;
      l_next.st_tgl = ~l_reg.st_tgl;
    end
    else if (tmo_hit)
    begin
      // Give the bus back so a stuck host cannot hang it
      l_next.state = L_IDLE;
      l_next.drive = 1'b0;
    end
    else
    begin
      case (l_reg.state)
        L_ADDR, L_PTR, L_WDATA:
        begin
          if (rise_c)
          begin
            l_next.shift = {l_reg.shift[6:0], l_reg.sda_s2};
            l_next.cnt   = l_reg.cnt + 4'h1;
          end
          else if (fall_c && l_reg.cnt == 4'h8)
          begin
            l_next.cnt   = 4'h0;
            l_next.drive = 1'b1;
            if (l_reg.state == L_ADDR)
            begin
              l_next.ara = l_reg.shift[7:1] == ARA_ADDR && l_reg.shift[0] && !l_reg.ara_s2;
              if (l_reg.shift[7:1] == {SLAVE_BASE, l_reg.ap_s2} || l_next.ara)
              begin
                l_next.state = L_ADDR_ACK;
                if (l_reg.shift[0])
                  l_next.rq_tgl = ~l_reg.rq_tgl;
              end
              else
              begin
                l_next.state = L_IDLE;
                l_next.drive = 1'b0;
              end
            end
            else if (l_reg.state == L_PTR)
            begin
              l_next.ptr     = l_reg.shift;
              l_next.hi_done = 1'b0;
              l_next.state   = L_PTR_ACK;
            end
            else
            begin
              if (l_reg.hi_done)
              begin
                l_next.wdata[7:0] = l_reg.shift;
                l_next.wr_tgl     = ~l_reg.wr_tgl;
              end
              else
                l_next.wdata[15:8] = l_reg.shift;
              l_next.hi_done = ~l_reg.hi_done;
              l_next.state   = L_WDATA_ACK;
            end
          end
        end
        L_ADDR_ACK:
        begin
          if (fall_c)
          begin
            if (l_reg.ptr != 8'h00 || l_reg.shift[0])
            begin
              if (l_reg.shift[0])
              begin
                l_next.shift   = l_reg.ara ? {SLAVE_BASE, l_reg.ap_s2, 1'b0} : l_reg.rdata[15:8];
                l_next.drive   = ~l_next.shift[7];
                l_next.hi_done = 1'b1;
                l_next.state   = L_RDATA;
              end
              else
              begin
                l_next.drive = 1'b0;
                l_next.state = L_PTR;
              end
            end
            else
            begin
              l_next.drive = 1'b0;
              l_next.state = L_PTR;
            end
          end
        end
        L_PTR_ACK, L_WDATA_ACK:
        begin
          if (fall_c)
          begin
            l_next.drive = 1'b0;
            l_next.state = L_WDATA;
          end
        end
        L_RDATA:
        begin
          if (fall_c)
          begin
            if (l_reg.cnt == 4'h7)
            begin
              l_next.cnt   = 4'h0;
              l_next.drive = 1'b0;
              l_next.state = L_RDATA_ACK;
            end
            else
            begin
              l_next.cnt   = l_reg.cnt + 4'h1;
              l_next.shift = {l_reg.shift[6:0], 1'b0};
              l_next.drive = ~l_reg.shift[6];
            end
          end
        end
        L_RDATA_ACK:
        begin
          if (rise_c && l_reg.sda_s2)
            l_next.state = L_IDLE;
          else if (fall_c)
          begin
            l_next.shift   = l_reg.hi_done ? l_reg.rdata[7:0] : l_reg.rdata[15:8];
            l_next.drive   = ~l_next.shift[7];
            l_next.hi_done = ~l_reg.hi_done;
            l_next.state   = L_RDATA;
          end
        end
        default:
          l_next.state = L_IDLE;
      endcase
    end
  end

  // Link state register
  always_ff @(posedge clk_link_in)
  begin
    if (lrst_s2)
    begin
      l_reg        <= '0;
      l_reg.scl_s1 <= 1'b1;
      l_reg.scl_s2 <= 1'b1;
      l_reg.scl_d  <= 1'b1;
      l_reg.sda_s1 <= 1'b1;
      l_reg.sda_s2 <= 1'b1;
      l_reg.sda_d  <= 1'b1;
      l_reg.state  <= L_IDLE;
    end
    else
      l_reg <= l_next;
  end

  // Open-drain data pin: only ever pulls low
  assign sda_out    = 1'b0;
  assign sda_oe_out = l_reg.drive;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seq_conv;
    upd;
  endsequence
  sequence seq_cfg_write;
    wr_evt && l_reg.ptr == PTR_CFG;
  endsequence

  a_crit_set_level: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    seq_conv ##0 (t_ext >= limits_in.crit) |=> s_reg.result[BIT_CRIT])
    else $error("critical flag missed at threshold");
  a_over_clear_hys: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    seq_conv ##0 (t_ext <= limits_in.upper - limits_in.hyst) |=> !s_reg.result[BIT_OVER])
    else $error("over flag not cleared below hysteresis");
  a_under_set_low: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    seq_conv ##0 (t_ext < limits_in.lower - limits_in.hyst) |=> s_reg.result[BIT_UNDER])
    else $error("under flag not set below limit");
  a_under_clear_lim: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    seq_conv ##0 (t_ext >= limits_in.lower) |=> !s_reg.result[BIT_UNDER])
    else $error("under flag not cleared at limit");
  a_sign_value_lsb: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    seq_conv |=> s_reg.result[BIT_SIGN] == $past(sensor_temp_in[10])
                 && s_reg.result[11:0] == {$past(sensor_temp_in), 1'b0})
    else $error("result value or sign wrong");
  a_ident_read_fixed: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    rq_evt && (l_reg.ptr == PTR_MAKER || l_reg.ptr == PTR_PART)
    |=> s_reg.rd_word == (l_reg.ptr == PTR_MAKER ? MAKER_ID : {PART_ID, PART_REV}))
    else $error("identity read wrong");
  a_cfg_reset_zero: assert property (@(posedge clk_sys_in)
    $fell(reset_in) |-> !s_reg.tmo_dis && !s_reg.ara_dis)
    else $error("config bits not zero after reset");
  a_cfg_lock_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    seq_cfg_write ##0 locked |=> $stable(s_reg.tmo_dis) && $stable(s_reg.ara_dis))
    else $error("config changed while locked");
  a_cfg_reserved_rd: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    rq_evt && l_reg.ptr == PTR_CFG |=> s_reg.rd_word[15:8] == 8'h00
                                       && s_reg.rd_word[6:1] == 6'h00)
    else $error("reserved config bits not zero");
  a_conv_restart: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    st_evt |=> s_reg.conv_cnt == 32'(CONV_CYCLES - 1) ##1 !upd)
    else $error("conversion timer not restarted on stop");
  a_result_frozen: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !upd |=> $stable(s_reg.result))
    else $error("result changed outside a conversion");

endmodule

`default_nettype wire

// File: temp_status_pkg.sv
// Constants, state encodings and carriers for the temperature readout block.
// Assumes a 100 MHz system clock and a free-running link sampling clock.
package temp_status_pkg;

  // ****************************************************************
  // Register pointers and field positions
  // ****************************************************************
  localparam logic [7:0] PTR_TEMP      = 8'h05;  // Temperature result
  localparam logic [7:0] PTR_MAKER     = 8'h06;  // Maker identifier
  localparam logic [7:0] PTR_PART      = 8'h07;  // Part identifier and revision
  localparam logic [7:0] PTR_CFG       = 8'h08;  // Bus time-out and alert config
  localparam int         BIT_CRIT      = 15;     // Critical trip flag
  localparam int         BIT_OVER      = 14;     // Over window flag
  localparam int         BIT_UNDER     = 13;     // Under window flag
  localparam int         BIT_SIGN      = 12;     // Sign of the reading
  localparam int         BIT_TMO_DIS   = 7;      // Bus time-out disable
  localparam int         BIT_ARA_DIS   = 0;      // Alert response disable
  localparam logic       CFG_RESET     = 1'b0;   // Reset value of both config bits
  localparam logic [15:0] TEMP_RESET   = 16'h0000;

  // ****************************************************************
  // Identity and addressing (values arbitrary, not a real part)
  // ****************************************************************
  localparam logic [15:0] MAKER_ID     = 16'h5a5a;  // Arbitrary value
  localparam logic [7:0]  PART_ID      = 8'h3c;     // Arbitrary value
  localparam logic [7:0]  PART_REV     = 8'h02;     // Arbitrary value
  localparam logic [3:0]  SLAVE_BASE   = 4'h3;      // Upper address bits
  localparam logic [6:0]  ARA_ADDR     = 7'h0c;     // Alert response address

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_SYS_MHZ       = 100;
  localparam int LINK_CLK_KHZ      = 8000;
  localparam int CONV_PERIOD_MS    = 100;  // Nominal conversion period
  localparam int CONV_MAX_MS       = 120;  // Upper bound, not enforced; bus stops restart the timer past it
  localparam int CONV_CYCLES_DFLT  = CONV_PERIOD_MS * 1000 * CLK_SYS_MHZ;
  localparam int TIMEOUT_MS        = 25;   // Clock-low time-out
  localparam int TIMEOUT_CYCLES_DFLT = TIMEOUT_MS * LINK_CLK_KHZ;

  // ****************************************************************
  // Link state machine and carriers
  // ****************************************************************
  typedef enum logic [3:0] {
    L_IDLE      = 4'b0000,
    L_ADDR      = 4'b0001,
    L_ADDR_ACK  = 4'b0010,
    L_PTR       = 4'b0011,
    L_PTR_ACK   = 4'b0100,
    L_WDATA     = 4'b0101,
    L_WDATA_ACK = 4'b0110,
    L_RDATA     = 4'b0111,
    L_RDATA_ACK = 4'b1000
  } link_state_e;

  typedef struct packed {
    logic signed [11:0] crit;   // Critical threshold
    logic signed [11:0] upper;  // Upper window limit
    logic signed [11:0] lower;  // Lower window limit
    logic signed [11:0] hyst;   // Hysteresis amount
  } limits_s;

endpackage

// File: host_model.sv
// Open-drain serial host model: start, stop and byte transfers.
// Assumes the bench resolves the data wire from every pull-down enable.
`timescale 1ns/1ps
`default_nettype none
// ********************
// Serial host model
// ********************
module host_model
#(
  parameter int HALF_NS = 1000  // SCL half period, at least 8 link clocks
)
(
  // Wire levels
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_low_out
);
  logic r;  // Sampled acknowledge

  // Idle bus: both lines released
  initial
  begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  // Data moves mid-low, is sampled mid-high
  task bit_io(input logic b, output logic s);
    #(HALF_NS/2) sda_low_out = !b;
    #(HALF_NS/2) scl_out = 1'b1;
    #(HALF_NS/2) s = sda_in;
    #(HALF_NS/2) scl_out = 1'b0;
  endtask

  // Start or repeated start
  task start();
    #(HALF_NS/2) sda_low_out = 1'b0;
    #(HALF_NS/2) scl_out = 1'b1;
    #(HALF_NS/2) sda_low_out = 1'b1;
    #(HALF_NS/2) scl_out = 1'b0;
  endtask

  // Stop leaves the bus idle
  task stop();
    #(HALF_NS/2) sda_low_out = 1'b1;
    #(HALF_NS/2) scl_out = 1'b1;
    #(HALF_NS/2) sda_low_out = 1'b0;
    #(HALF_NS/2);
  endtask

  // Byte out, msb first, then the device's acknowledge
  task wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // Byte in; last byte is answered with a NACK
  task rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// File: test_temp_status_id_smbus_cfg.sv
// Self-checking bench for the readout block against an integer model.
// Assumes the host model file; short conversion and time-out counts.
`timescale 1ns/1ps
`default_nettype none
// ********************
// Bench
// ********************
module test_temp_status_id_smbus_cfg;
  import temp_status_pkg::*;
  localparam logic [7:0] AW = {SLAVE_BASE, 3'b101, 1'b0};  // Own write address
  localparam int C = 300, U = 200, L = -100, HY = 40;      // Limits in eighths
  logic        clk_sys_in, clk_link_in, reset_in, crit_lock_in, window_lock_in;
  logic [10:0] sensor_temp_in;  // Reading fed to the converter side
  limits_s     limits_in;       // Fixed comparison limits
  logic        scl, sda_low, sda_oe_out, sda_out, a, ack_all;
  wire logic   sda = !(sda_low || sda_oe_out);  // Pull-up wins when released
  int          n_fail, check_count, fc, fo, fu, seed, t;
  logic [15:0] v, e;
  int          temps[10] = '{210, 200, 180, 150, 300, 270, 250, -141, -120, 0};
  logic [1:0]  lk[4] = '{2'b00, 2'b10, 2'b01, 2'b00};  // Lock states
  logic [15:0] wv[4] = '{16'hffff, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] ev[4] = '{16'h0081, 16'h0081, 16'h0081, 16'h0000};

  // Clocks, link phase unrelated to the system clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    clk_link_in = 1'b0;
    #37;
    forever #62.5 clk_link_in = ~clk_link_in;
  end

  temp_status_id_smbus_cfg #(.CONV_CYCLES(200), .TIMEOUT_CYCLES(100)) i_temp_status_id_smbus_cfg
  (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .sensor_temp_in(sensor_temp_in),
    .limits_in(limits_in), .crit_lock_in(crit_lock_in), .window_lock_in(window_lock_in),
    .clk_link_in(clk_link_in), .addr_pins_in(3'b101), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out)
  );
  host_model i_host_model (.sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

  // Compare tasks, one per kind of result
  task check16(input string nm, input logic [15:0] ex, input logic [15:0] g);
    check_count++;
    if (g !== ex)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, ex, g);
    end
  endtask
  task check1(input string nm, input logic ex, input logic g);
    check_count++;
    if (g !== ex)
    begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", nm, ex, g);
    end
  endtask
  task stop_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Register transfers; acknowledges collect into one flag
  task tx(input logic [7:0] d);
    i_host_model.wr_byte(d, a);
    ack_all &= a;
  endtask
  task wr_reg(input logic [7:0] p, input logic [15:0] d);
    i_host_model.start();
    tx(AW);
    tx(p);
    tx(d[15:8]);
    tx(d[7:0]);
    i_host_model.stop();
  endtask
  task rd_reg(input logic [7:0] p, input logic set);
    if (set)
    begin
      i_host_model.start();
      tx(AW);
      tx(p);
    end
    i_host_model.start();
    tx(AW | 8'h01);
    i_host_model.rd_byte(1'b0, v[15:8]);
    i_host_model.rd_byte(1'b1, v[7:0]);
    i_host_model.stop();
  endtask

  // Flag model: a set upper flag holds against limit minus hysteresis;
  // the under flag sets below limit minus hysteresis and clears at the limit
  task upd(input int x);
    fc = fc ? int'(x >= C - HY) : int'(x >= C);
    fo = fo ? int'(x > U - HY) : int'(x > U);
    fu = fu ? int'(x < L) : int'(x < L - HY);
    e = {fc[0], fo[0], fu[0], sensor_temp_in[10], sensor_temp_in, 1'b0};
  endtask

  // Hang guard
  initial
  begin
    #4ms;
    n_fail++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    seed = 32'h42fc;
    {n_fail, check_count, fc, fo, fu} = '0;
    {reset_in, ack_all, crit_lock_in, window_lock_in} = 4'b1100;
    sensor_temp_in = '0;
    limits_in = '{crit: 12'(C), upper: 12'(U), lower: 12'(L), hyst: 12'(HY)};
    repeat (16) @(posedge clk_link_in);
    @(negedge clk_sys_in) reset_in = 1'b0;
    repeat (8) @(posedge clk_link_in);
    // Start off the link clock edge so pin changes never race its sampling
    @(negedge clk_sys_in);
    rd_reg(PTR_CFG, 1'b1);
    check16("cfg reset", 16'h0000, v);
    rd_reg(PTR_MAKER, 1'b1);
    check16("maker", MAKER_ID, v);
    rd_reg(PTR_PART, 1'b1);
    check16("part", {PART_ID, PART_REV}, v);
    wr_reg(PTR_TEMP, 16'hffff);
    wr_reg(PTR_MAKER, 16'h0000);
    rd_reg(PTR_MAKER, 1'b0);
    check16("maker kept", MAKER_ID, v);
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clk_sys_in) {crit_lock_in, window_lock_in} = lk[k];
      wr_reg(PTR_CFG, wv[k]);
      rd_reg(PTR_CFG, 1'b0);
      check16("cfg", ev[k], v);
    end
    rd_reg(PTR_TEMP, 1'b1);
    check16("temp kept", 16'h0000, v);
    for (int k = 0; k < 10; k++)
    begin
      t = (k == 9) ? $random(seed) % 1024 : temps[k];
      @(negedge clk_sys_in) sensor_temp_in = t[10:0];
      repeat (450) @(posedge clk_sys_in);
      rd_reg(PTR_TEMP, 1'b0);
      upd(t);
      check16("temp", e, v);
    end
    i_host_model.start();
    i_host_model.wr_byte(AW ^ 8'h02, a);
    i_host_model.stop();
    check1("foreign address ack", 1'b0, a);
    // Alert response read answers with the own address while enabled
    i_host_model.start();
    tx({ARA_ADDR, 1'b1});
    i_host_model.rd_byte(1'b1, v[7:0]);
    i_host_model.stop();
    check16("ara answer", {8'h00, AW}, {8'h00, v[7:0]});
    check1("acks", 1'b1, ack_all);
    check1("data pin level", 1'b0, sda_out);
    stop_test();
  end
endmodule
`default_nettype wire
